// ==== inc/rcw_pkg.sv ====
// Package with register map, field layout and codes of the calendar register windows
// Contract
// - Time pointer sits in calendar config bits 9:8
// - Time window maps seconds, hours, day, year pairs
// - Time high-byte write decrements pointer, stops at 00
// - Pointer 00 keeps minutes/seconds until rewritten
// - Alarm pointer sits in alarm config bits 9:8
// - Alarm window maps three pairs, code 11 empty
// - Alarm high-byte write decrements, holds at 00
// - Any alarm window read decrements alarm pointer
// - Any time window read decrements time pointer
// - Low-byte writes never move a pointer
// - Time register writes need timer write enable
// - Enable set only right after 55h, AAh keys
// - Clock select 00 crystal, 01 RC oscillator
// - Clock select 10/11 mains at 50/60 Hz
package rcw_pkg;

    localparam int DW = 16;
    localparam int AW = 4;

    // Word addresses of the registers
    localparam logic [3:0] ADDR_CAL_CFG  = 4'h0;
    localparam logic [3:0] ADDR_CAL_CFG1 = 4'h1;
    localparam logic [3:0] ADDR_ALM_CFG  = 4'h2;
    localparam logic [3:0] ADDR_PWR_CTL  = 4'h3;
    localparam logic [3:0] ADDR_TIME_WIN = 4'h4;
    localparam logic [3:0] ADDR_ALM_WIN  = 4'h5;
    localparam logic [3:0] ADDR_KEY      = 4'h6;

    // Field positions
    localparam int PTR_LSB    = 8;
    localparam int WREN_BIT   = 13;
    localparam int CLKSEL_LSB = 0;
    localparam int LANE_HI    = 1;

    // Reset values
    localparam logic [1:0] PTR_RST    = 2'h0;
    localparam logic [1:0] CLKSEL_RST = 2'h0;
    localparam logic [7:0] BYTE_RST   = 8'h00;

    // Unlock keys
    localparam logic [7:0] KEY_FIRST  = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;

    // Empty bytes of each window, index {pointer, lane}
    localparam logic [7:0] TIME_EMPTY = 8'h80;
    localparam logic [7:0] ALM_EMPTY  = 8'hC0;

    // Reference clock selection codes
    typedef enum logic [1:0] {
        CS_XTAL   = 2'b00,
        CS_RCOSC  = 2'b01,
        CS_MAIN50 = 2'b10,
        CS_MAIN60 = 2'b11
    } rcw_clksel_t;

    // Unlock sequencer states
    typedef enum logic [1:0] {
        UL_IDLE = 2'b00,
        UL_GOT1 = 2'b01,
        UL_OPEN = 2'b10
    } rcw_unlock_t;

endpackage

// ==== src/rcw_top.sv ====
// Register windows, write lock and reference clock select of the calendar clock unit
//
// The strobed register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module rcw_top
    import rcw_pkg::*;
(
    input  wire logic        SYS_CLK_I,     // System clock, 100 MHz
    input  wire logic        RST_B_I,       // Sync reset, active low
    input  wire logic        CE_I,          // Clock enable, freezes all
    input  wire logic [3:0]  ADDR_I,        // Register word address
    input  wire logic [15:0] WDATA_I,       // Write data
    input  wire logic        WR_I,          // Write strobe
    input  wire logic [1:0]  WR_BE_I,       // Write byte lanes
    input  wire logic        RD_I,          // Read strobe
    output logic      [15:0] RDATA_O,       // Read data, cycle after read
    input  wire logic        XTAL_TICK_I,   // Crystal oscillator tick
    input  wire logic        RCOSC_TICK_I,  // RC oscillator tick
    input  wire logic        MAINS_TICK_I,  // Mains line tick
    output logic             REF_TICK_O,    // Selected reference tick
    output logic             MAINS_60HZ_O,  // Mains runs at 60 Hz
    output logic      [1:0]  CLK_SEL_O,     // Clock select field
    output logic             TIMER_WREN_O,  // Timer write enable
    output logic      [7:0]  TIME_SEC_O,    // Seconds
    output logic      [7:0]  TIME_MIN_O,    // Minutes
    output logic      [7:0]  TIME_HOUR_O,   // Hours
    output logic      [7:0]  TIME_WDAY_O,   // Weekday
    output logic      [7:0]  TIME_DAY_O,    // Day
    output logic      [7:0]  TIME_MONTH_O,  // Month
    output logic      [7:0]  TIME_YEAR_O,   // Year
    output logic      [7:0]  ALM_SEC_O,     // Alarm seconds
    output logic      [7:0]  ALM_MIN_O,     // Alarm minutes
    output logic      [7:0]  ALM_HOUR_O,    // Alarm hours
    output logic      [7:0]  ALM_WDAY_O,    // Alarm weekday
    output logic      [7:0]  ALM_DAY_O,     // Alarm day
    output logic      [7:0]  ALM_MONTH_O    // Alarm month
);

    // Bus decode
    logic        wr_cal_cfg;
    logic        wr_cal_cfg1;
    logic        wr_alm_cfg;
    logic        wr_pwr;
    logic        wr_key;
    logic        rd_twin;
    logic        rd_awin;
    logic [1:0]  twin_be;
    logic [1:0]  awin_be;

    // Window instance results
    logic [1:0]  tptr;
    logic [1:0]  aptr;
    logic [15:0] tword;
    logic [15:0] aword;
    logic [63:0] tbytes;
    logic [63:0] abytes;

    // Control state
    rcw_unlock_t ul_ff;
    rcw_unlock_t nxt_ul;
    logic        wren_ff;
    logic        nxt_wren;
    logic [1:0]  clksel_ff;
    logic [1:0]  nxt_clksel;

    // Output registers
    logic [15:0] rdata_ff;
    logic [15:0] nxt_rdata;
    logic        ref_ff;
    logic        nxt_ref;
    logic        mains_ff;
    logic        nxt_mains;
    // Byte copies, one cycle behind storage
    logic [63:0] tout_ff;
    logic [63:0] nxt_tout;
    logic [63:0] aout_ff;
    logic [63:0] nxt_aout;

    // Returns true when an access hits the given address
    function automatic logic hit(input logic [3:0] a, input logic [3:0] reg_a);
        return a == reg_a;
    endfunction

    // Address decode of writes and window reads
    always_comb begin
        wr_cal_cfg  = 1'b0;
        wr_cal_cfg1 = 1'b0;
        wr_alm_cfg  = 1'b0;
        wr_pwr      = 1'b0;
        wr_key      = 1'b0;
        twin_be     = 2'b00;
        awin_be     = 2'b00;
        // Unmapped addresses match no branch and are dropped
        if (WR_I) begin
            if (hit(ADDR_I, ADDR_CAL_CFG)) begin
                wr_cal_cfg = 1'b1;
            end else if (hit(ADDR_I, ADDR_CAL_CFG1)) begin
                wr_cal_cfg1 = 1'b1;
            end else if (hit(ADDR_I, ADDR_ALM_CFG)) begin
                wr_alm_cfg = 1'b1;
            end else if (hit(ADDR_I, ADDR_PWR_CTL)) begin
                wr_pwr = 1'b1;
            end else if (hit(ADDR_I, ADDR_TIME_WIN)) begin
                twin_be = WR_BE_I;
            end else if (hit(ADDR_I, ADDR_ALM_WIN)) begin
                awin_be = WR_BE_I;
            end else if (hit(ADDR_I, ADDR_KEY)) begin
                wr_key = 1'b1;
            end
        end
    end

    // The core reads whole words, so any window read counts
    assign rd_twin = RD_I && hit(ADDR_I, ADDR_TIME_WIN);
    assign rd_awin = RD_I && hit(ADDR_I, ADDR_ALM_WIN);

    // Time window; byte writes gated by the write enable, pointer still moves.
    // A locked high-lane write steps the pointer just as an open one does.
    rcw_win #(
        .EMPTY_MASK (TIME_EMPTY)
    ) u_time_win (
        .clk_i     (SYS_CLK_I),
        .rst_b_i   (RST_B_I),
        .ce_i      (CE_I),
        .ptr_ld_i  (wr_cal_cfg && WR_BE_I[LANE_HI]),
        .ptr_val_i (WDATA_I[PTR_LSB +: 2]),
        .rd_i      (rd_twin),
        .wr_be_i   (twin_be),
        .wr_ok_i   (wren_ff),
        .wdata_i   (WDATA_I),
        .ptr_o     (tptr),
        .word_o    (tword),
        .bytes_o   (tbytes)
    );

    // Alarm window; always writable
    rcw_win #(
        .EMPTY_MASK (ALM_EMPTY)
    ) u_alm_win (
        .clk_i     (SYS_CLK_I),
        .rst_b_i   (RST_B_I),
        .ce_i      (CE_I),
        .ptr_ld_i  (wr_alm_cfg && WR_BE_I[LANE_HI]),
        .ptr_val_i (WDATA_I[PTR_LSB +: 2]),
        .rd_i      (rd_awin),
        .wr_be_i   (awin_be),
        .wr_ok_i   (1'b1),
        .wdata_i   (WDATA_I),
        .ptr_o     (aptr),
        .word_o    (aword),
        .bytes_o   (abytes)
    );

    // Unlock sequencer and write enable.
    // The open state lasts one cycle, so any stray write between the
    // second key and the enable write closes the lock again.
    always_comb begin
        nxt_ul   = ul_ff;
        nxt_wren = wren_ff;
        if (ul_ff == UL_OPEN) begin
            nxt_ul = UL_IDLE;
        end
        if (WR_I) begin
            case (ul_ff)
                UL_IDLE: begin
                    if (wr_key && WR_BE_I[0] && WDATA_I[7:0] == KEY_FIRST) begin
                        nxt_ul = UL_GOT1;
                    end
                end
                UL_GOT1: begin
                    if (wr_key && WR_BE_I[0] && WDATA_I[7:0] == KEY_SECOND) begin
                        nxt_ul = UL_OPEN;
                    end else if (wr_key && WR_BE_I[0] && WDATA_I[7:0] == KEY_FIRST) begin
                        // A repeated first key restarts the pair instead of aborting
                        nxt_ul = UL_GOT1;
                    end else begin
                        nxt_ul = UL_IDLE;
                    end
                end
                UL_OPEN: begin
                    nxt_ul = UL_IDLE;
                end
                default: begin
                    nxt_ul = UL_IDLE;
                end
            endcase
        end
        if (wr_cal_cfg1 && WR_BE_I[LANE_HI]) begin
            if (!WDATA_I[WREN_BIT]) begin
                nxt_wren = 1'b0;  // Clearing is never locked
            end else if (ul_ff == UL_OPEN) begin
                nxt_wren = 1'b1;
            end
        end
    end

    // Sequencer and write enable registers
    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_B_I) begin
            ul_ff   <= UL_IDLE;
            wren_ff <= 1'b0;
        end else if (CE_I) begin
            ul_ff   <= nxt_ul;
            wren_ff <= nxt_wren;
        end
    end

    // Clock select field and selected reference tick
    always_comb begin
        nxt_clksel = clksel_ff;
        // The select field is written from the low lane only
        if (wr_pwr && WR_BE_I[0]) begin
            nxt_clksel = WDATA_I[CLKSEL_LSB +: 2];
        end
        // Both mains codes route the same pin; only the rate flag differs
        case (rcw_clksel_t'(clksel_ff))
            CS_XTAL:   nxt_ref = XTAL_TICK_I;
            CS_RCOSC:  nxt_ref = RCOSC_TICK_I;
            CS_MAIN50: nxt_ref = MAINS_TICK_I;
            CS_MAIN60: nxt_ref = MAINS_TICK_I;
            default:   nxt_ref = XTAL_TICK_I;
        endcase
        // Rate flag follows the next select, so it changes with the field
        nxt_mains = (nxt_clksel == CS_MAIN60);
    end

    // Select, rate flag and sampled tick
    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_B_I) begin
            clksel_ff <= CLKSEL_RST;
            mains_ff  <= 1'b0;
            ref_ff    <= 1'b0;
        end else if (CE_I) begin
            clksel_ff <= nxt_clksel;
            mains_ff  <= nxt_mains;
            ref_ff    <= nxt_ref;
        end
    end

    // Read mux; data stand only in the cycle after the strobe.
    // The window word is taken before the pointer moves.
    always_comb begin
        // Unmapped addresses and the key register fall through and read zero
        nxt_rdata = 16'h0000;
        if (RD_I) begin
            if (hit(ADDR_I, ADDR_CAL_CFG)) begin
                nxt_rdata[PTR_LSB +: 2] = tptr;
            end else if (hit(ADDR_I, ADDR_CAL_CFG1)) begin
                nxt_rdata[WREN_BIT] = wren_ff;
            end else if (hit(ADDR_I, ADDR_ALM_CFG)) begin
                nxt_rdata[PTR_LSB +: 2] = aptr;
            end else if (hit(ADDR_I, ADDR_PWR_CTL)) begin
                nxt_rdata[CLKSEL_LSB +: 2] = clksel_ff;
            end else if (hit(ADDR_I, ADDR_TIME_WIN)) begin
                nxt_rdata = tword;
            end else if (hit(ADDR_I, ADDR_ALM_WIN)) begin
                nxt_rdata = aword;
            end
        end
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_B_I) begin
            rdata_ff <= 16'h0000;
        end else if (CE_I) begin
            rdata_ff <= nxt_rdata;
        end
    end

    // Byte copies for the output pins. They trail storage by one cycle,
    // the price of keeping every output on a flop.
    always_comb begin
        nxt_tout = tbytes;
        nxt_aout = abytes;
    end

    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_B_I) begin
            tout_ff <= 64'h0000_0000_0000_0000;
            aout_ff <= 64'h0000_0000_0000_0000;
        end else if (CE_I) begin
            tout_ff <= nxt_tout;
            aout_ff <= nxt_aout;
        end
    end

    // Outputs straight from flip-flops; byte index is {pointer, lane}.
    // A window write shows on the byte pins two cycles after its strobe.
    assign RDATA_O      = rdata_ff;
    assign REF_TICK_O   = ref_ff;
    assign MAINS_60HZ_O = mains_ff;
    assign CLK_SEL_O    = clksel_ff;
    assign TIMER_WREN_O = wren_ff;
    assign TIME_SEC_O   = tout_ff[7:0];
    assign TIME_MIN_O   = tout_ff[15:8];
    assign TIME_HOUR_O  = tout_ff[23:16];
    assign TIME_WDAY_O  = tout_ff[31:24];
    assign TIME_DAY_O   = tout_ff[39:32];
    assign TIME_MONTH_O = tout_ff[47:40];
    assign TIME_YEAR_O  = tout_ff[55:48];
    assign ALM_SEC_O    = aout_ff[7:0];
    assign ALM_MIN_O    = aout_ff[15:8];
    assign ALM_HOUR_O   = aout_ff[23:16];
    assign ALM_WDAY_O   = aout_ff[31:24];
    assign ALM_DAY_O    = aout_ff[39:32];
    assign ALM_MONTH_O  = aout_ff[47:40];

endmodule

// ==== src/rcw_win.sv ====
// Pointer-indexed byte window with auto-decrementing pointer
`timescale 1ns/1ps
module rcw_win
    import rcw_pkg::*;
#(
    parameter logic [7:0] EMPTY_MASK = 8'h00
) (
    input  wire logic        clk_i,      // System clock
    input  wire logic        rst_b_i,    // Sync reset, active low
    input  wire logic        ce_i,       // Clock enable
    input  wire logic        ptr_ld_i,   // Load pointer from software
    input  wire logic [1:0]  ptr_val_i,  // New pointer value
    input  wire logic        rd_i,       // Window read
    input  wire logic [1:0]  wr_be_i,    // Window write lanes
    input  wire logic        wr_ok_i,    // Byte writes allowed
    input  wire logic [15:0] wdata_i,    // Write data
    output logic      [1:0]  ptr_o,      // Current pointer
    output logic      [15:0] word_o,     // Window content now
    output logic      [63:0] bytes_o     // All bytes, index*8
);

    logic [1:0] ptr_ff;
    logic [1:0] nxt_ptr;
    logic [7:0] mem_ff  [0:7];
    logic [7:0] nxt_mem [0:7];
    logic [2:0] idx_lo;
    logic [2:0] idx_hi;

    assign idx_lo = {ptr_ff, 1'b0};
    assign idx_hi = {ptr_ff, 1'b1};
    assign ptr_o  = ptr_ff;
    // Empty bytes read as zero
    assign word_o = {EMPTY_MASK[idx_hi] ? BYTE_RST : mem_ff[idx_hi],
                     EMPTY_MASK[idx_lo] ? BYTE_RST : mem_ff[idx_lo]};

    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_flat
            assign bytes_o[g*8 +: 8] = mem_ff[g];
        end
    endgenerate

    // Pointer and byte next values
    always_comb begin
        nxt_ptr = ptr_ff;
        for (int i = 0; i < 8; i++) begin
            nxt_mem[i] = mem_ff[i];
        end
        if (wr_ok_i && wr_be_i[0] && !EMPTY_MASK[idx_lo]) begin
            nxt_mem[idx_lo] = wdata_i[7:0];
        end
        if (wr_ok_i && wr_be_i[LANE_HI] && !EMPTY_MASK[idx_hi]) begin
            nxt_mem[idx_hi] = wdata_i[15:8];
        end
        if (ptr_ld_i) begin
            nxt_ptr = ptr_val_i;
        end else if ((rd_i || wr_be_i[LANE_HI]) && ptr_ff != 2'b00) begin
            // Saturates at 00 so minutes/seconds stay visible
            nxt_ptr = ptr_ff - 2'b01;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            ptr_ff <= PTR_RST;
            for (int i = 0; i < 8; i++) begin
                mem_ff[i] <= BYTE_RST;
            end
        end else if (ce_i) begin
            ptr_ff <= nxt_ptr;
            for (int i = 0; i < 8; i++) begin
                mem_ff[i] <= nxt_mem[i];
            end
        end
    end

endmodule

// ==== verif/rcw_checker.sv ====
// Concurrent checks on the ports of the calendar register window block
`timescale 1ns/1ps
module rcw_checker
    import rcw_pkg::*;
(
    input wire logic        SYS_CLK_I,    // Clock
    input wire logic        RST_B_I,      // Reset, active low
    input wire logic        CE_I,         // Clock enable
    input wire logic [3:0]  ADDR_I,       // Address
    input wire logic [15:0] WDATA_I,      // Write data
    input wire logic        WR_I,         // Write strobe
    input wire logic [1:0]  WR_BE_I,      // Byte lanes
    input wire logic        RD_I,         // Read strobe
    input wire logic [15:0] RDATA_O,      // Read data
    input wire logic        XTAL_TICK_I,  // Crystal tick
    input wire logic        RCOSC_TICK_I, // RC tick
    input wire logic        MAINS_TICK_I, // Mains tick
    input wire logic        REF_TICK_O,   // Selected tick
    input wire logic        MAINS_60HZ_O, // 60 Hz flag
    input wire logic [1:0]  CLK_SEL_O,    // Clock select
    input wire logic        TIMER_WREN_O, // Write enable
    input wire logic [7:0]  TIME_SEC_O,   // Seconds
    input wire logic [7:0]  TIME_MIN_O,   // Minutes
    input wire logic [7:0]  TIME_HOUR_O,  // Hours
    input wire logic [7:0]  TIME_WDAY_O,  // Weekday
    input wire logic [7:0]  TIME_DAY_O,   // Day
    input wire logic [7:0]  TIME_MONTH_O, // Month
    input wire logic [7:0]  TIME_YEAR_O   // Year
);
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (!RST_B_I);

    // Both keys on adjacent enabled cycles, then the enable write
    sequence key_pair_s;
        CE_I && WR_I && WR_BE_I[0] && ADDR_I == ADDR_KEY && WDATA_I[7:0] == KEY_FIRST
        ##1 CE_I && WR_I && WR_BE_I[0] && ADDR_I == ADDR_KEY && WDATA_I[7:0] == KEY_SECOND;
    endsequence
    sequence wren_set_s;
        CE_I && WR_I && WR_BE_I[1] && ADDR_I == ADDR_CAL_CFG1 && WDATA_I[WREN_BIT];
    endsequence

    // Reference tick follows the selected source one cycle late
    ref_crystal_a: assert property (CE_I && CLK_SEL_O == 2'h0 |=> REF_TICK_O == $past(XTAL_TICK_I))
        else $error("crystal tick not routed");
    ref_rc_a: assert property (CE_I && CLK_SEL_O == 2'h1 |=> REF_TICK_O == $past(RCOSC_TICK_I))
        else $error("rc tick not routed");
    ref_mains_a: assert property (CE_I && CLK_SEL_O[1] |=> REF_TICK_O == $past(MAINS_TICK_I))
        else $error("mains tick not routed");
    mains_flag_a: assert property (MAINS_60HZ_O == (CLK_SEL_O == 2'h3))
        else $error("mains rate flag wrong");
    clk_sel_wr_a: assert property (CE_I && WR_I && WR_BE_I[0] && ADDR_I == ADDR_PWR_CTL
        |=> CLK_SEL_O == $past(WDATA_I[1:0])) else $error("clock select not written");

    // Read data only in the cycle after a read, zero for unmapped and key
    rd_idle_a: assert property (CE_I && !RD_I |=> RDATA_O == 16'h0000)
        else $error("read data outside read slot");
    unmapped_rd_a: assert property (CE_I && RD_I && ADDR_I >= ADDR_KEY |=> RDATA_O == 16'h0000)
        else $error("unmapped read not zero");

    // Write enable rises only right after the key pair
    unlock_ok_a: assert property (key_pair_s ##1 wren_set_s |=> TIMER_WREN_O)
        else $error("unlock sequence did not set enable");
    wren_guard_a: assert property ($rose(TIMER_WREN_O) |-> $past(WR_I && ADDR_I == ADDR_CAL_CFG1)
        && $past(WR_I && ADDR_I == ADDR_KEY && WDATA_I[7:0] == KEY_SECOND, 2)) else $error("enable set without keys");

    // Time bytes copy storage one cycle late, so a locked cycle shows two later
    time_lock_a: assert property (!TIMER_WREN_O |-> ##2 $stable({TIME_SEC_O, TIME_MIN_O, TIME_HOUR_O,
        TIME_WDAY_O, TIME_DAY_O, TIME_MONTH_O, TIME_YEAR_O})) else $error("time changed while locked");
    freeze_a: assert property (!CE_I |=> $stable(CLK_SEL_O) && $stable(TIMER_WREN_O))
        else $error("state moved with enable low");
endmodule

// ==== verif/test_rtc_register_window_access.sv ====
// Self-checking bench for the calendar register windows
`timescale 1ns/1ps
module test_rtc_register_window_access
    import rcw_pkg::*;
;
    logic        SYS_CLK_I = 1'b0, RST_B_I = 1'b0, CE_I = 1'b1, WR_I = 1'b0, RD_I = 1'b0;
    logic        XTAL_TICK_I = 1'b0, RCOSC_TICK_I = 1'b0, MAINS_TICK_I = 1'b0;
    logic [3:0]  ADDR_I = 4'h0;
    logic [1:0]  WR_BE_I = 2'h0;
    logic [15:0] WDATA_I = 16'h0000;
    logic [15:0] RDATA_O;
    logic        REF_TICK_O, MAINS_60HZ_O, TIMER_WREN_O;
    logic [1:0]  CLK_SEL_O;
    logic [7:0]  TIME_SEC_O, TIME_MIN_O, TIME_HOUR_O, TIME_WDAY_O, TIME_DAY_O, TIME_MONTH_O, TIME_YEAR_O;
    logic [7:0]  ALM_SEC_O, ALM_MIN_O, ALM_HOUR_O, ALM_WDAY_O, ALM_DAY_O, ALM_MONTH_O;
    int          err_count = 0;
    int          checks_done = 0;

    rcw_top rcw_top_inst (.*);

    // Free-running 100 MHz clock
    always #5 SYS_CLK_I = ~SYS_CLK_I;

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Strobe stays up so writes can run back to back; idle drops it
    task automatic wr(input logic [3:0] a, input logic [15:0] d, input logic [1:0] be);
        ADDR_I <= a;
        WDATA_I <= d;
        WR_BE_I <= be;
        WR_I <= 1'b1;
        RD_I <= 1'b0;
        @(posedge SYS_CLK_I);
    endtask

    // Returns just after the edge, so outputs checked next have settled
    task automatic idle(input int n);
        WR_I <= 1'b0;
        RD_I <= 1'b0;
        repeat (n) @(posedge SYS_CLK_I);
        #1;
    endtask

    // Read data is sampled just after the edge, as it stands one cycle only
    task automatic rd(input logic [3:0] a, input logic [15:0] exp, input string what);
        ADDR_I <= a;
        RD_I <= 1'b1;
        WR_I <= 1'b0;
        @(posedge SYS_CLK_I);
        RD_I <= 1'b0;
        #1;
        check(what, RDATA_O, exp);
        @(posedge SYS_CLK_I);
    endtask

    task automatic t_lock;
        check("reset wren", {15'h0, TIMER_WREN_O}, 16'h0000);
        check("reset clock select", {14'h0, CLK_SEL_O}, 16'h0000);
        rd(4'hF, 16'h0000, "unmapped read");
        rd(ADDR_KEY, 16'h0000, "key read");
        wr(ADDR_TIME_WIN, 16'h1234, 2'h3);
        wr(ADDR_KEY, 16'h0055, 2'h1);
        wr(ADDR_CAL_CFG1, 16'h2000, 2'h2);
        idle(3);
        check("locked seconds", {TIME_MIN_O, TIME_SEC_O}, 16'h0000);
        check("wren without key", {15'h0, TIMER_WREN_O}, 16'h0000);
        wr(ADDR_KEY, 16'h0055, 2'h1);
        wr(ADDR_KEY, 16'h00AA, 2'h1);
        idle(1);
        wr(ADDR_CAL_CFG1, 16'h2000, 2'h2);
        idle(2);
        check("wren after gap", {15'h0, TIMER_WREN_O}, 16'h0000);
        wr(ADDR_KEY, 16'h0055, 2'h1);
        wr(ADDR_KEY, 16'h00AA, 2'h1);
        wr(ADDR_CAL_CFG1, 16'h2000, 2'h2);
        idle(2);
        check("wren after keys", {15'h0, TIMER_WREN_O}, 16'h0001);
        rd(ADDR_CAL_CFG1, 16'h2000, "wren read back");
        $display("lock test done");
    endtask

    // Pointer walks 11 down to 00 by high-lane writes, then sticks
    task automatic t_time;
        wr(ADDR_CAL_CFG, 16'h0300, 2'h2);
        for (int p = 3; p >= 0; p--)
            wr(ADDR_TIME_WIN, {4'h1, p[3:0], 4'h2, p[3:0]}, 2'h3);
        wr(ADDR_TIME_WIN, 16'h305A, 2'h3);
        wr(ADDR_CAL_CFG, 16'h0100, 2'h2);
        wr(ADDR_TIME_WIN, 16'h00C3, 2'h1);
        idle(3);
        check("year month", {TIME_YEAR_O, TIME_MONTH_O}, 16'h2312);
        check("day weekday", {TIME_DAY_O, TIME_WDAY_O}, 16'h2211);
        check("minutes seconds out", {TIME_MIN_O, TIME_SEC_O}, 16'h305A);
        check("hours out", {8'h00, TIME_HOUR_O}, 16'h00C3);
        rd(ADDR_TIME_WIN, 16'h11C3, "weekday hours");
        rd(ADDR_TIME_WIN, 16'h305A, "minutes seconds");
        rd(ADDR_TIME_WIN, 16'h305A, "pointer held");
        wr(ADDR_CAL_CFG, 16'h0300, 2'h2);
        idle(1);
        rd(ADDR_TIME_WIN, 16'h0023, "year empty high");
        wr(ADDR_CAL_CFG1, 16'h0000, 2'h2);
        wr(ADDR_CAL_CFG, 16'h0200, 2'h2);
        idle(2);
        check("wren cleared", {15'h0, TIMER_WREN_O}, 16'h0000);
        rd(ADDR_TIME_WIN, 16'h1222, "month day");
        rd(ADDR_CAL_CFG, 16'h0100, "time pointer read");
        rd(ADDR_CAL_CFG1, 16'h0000, "wren read cleared");
        $display("time window test done");
    endtask

    task automatic t_alarm;
        wr(ADDR_ALM_CFG, 16'h0300, 2'h2);
        for (int p = 3; p >= 0; p--)
            wr(ADDR_ALM_WIN, {4'h4, p[3:0], 4'h6, p[3:0]}, 2'h3);
        wr(ADDR_ALM_WIN, 16'h4770, 2'h3);
        wr(ADDR_ALM_CFG, 16'h0300, 2'h2);
        idle(3);
        check("alarm month day", {ALM_MONTH_O, ALM_DAY_O}, 16'h4262);
        check("alarm minutes seconds out", {ALM_MIN_O, ALM_SEC_O}, 16'h4770);
        check("alarm weekday hours out", {ALM_WDAY_O, ALM_HOUR_O}, 16'h4161);
        rd(ADDR_ALM_CFG, 16'h0300, "alarm pointer read");
        rd(ADDR_ALM_WIN, 16'h0000, "alarm empty");
        rd(ADDR_ALM_WIN, 16'h4262, "alarm month day");
        rd(ADDR_ALM_WIN, 16'h4161, "alarm weekday hours");
        rd(ADDR_ALM_WIN, 16'h4770, "alarm minutes seconds");
        rd(ADDR_ALM_WIN, 16'h4770, "alarm pointer held");
        $display("alarm window test done");
    endtask

    // Only the selected source is driven high, then all are inverted
    task automatic t_clk;
        for (int c = 0; c < 4; c++) begin
            wr(ADDR_PWR_CTL, {14'h0, c[1:0]}, 2'h1);
            XTAL_TICK_I <= (c == 0);
            RCOSC_TICK_I <= (c == 1);
            MAINS_TICK_I <= (c > 1);
            idle(3);
            check("ref tick high", {14'h0, MAINS_60HZ_O, REF_TICK_O}, {14'h0, c == 3, 1'b1});
            XTAL_TICK_I <= (c != 0);
            RCOSC_TICK_I <= (c != 1);
            MAINS_TICK_I <= (c < 2);
            idle(3);
            check("ref tick low", {14'h0, MAINS_60HZ_O, REF_TICK_O}, {14'h0, c == 3, 1'b0});
            check("clock select out", {14'h0, CLK_SEL_O}, {14'h0, c[1:0]});
            rd(ADDR_PWR_CTL, {14'h0, c[1:0]}, "clock select read");
        end
        CE_I <= 1'b0;
        wr(ADDR_PWR_CTL, 16'h0000, 2'h1);
        idle(2);
        CE_I <= 1'b1;
        check("frozen select", {14'h0, CLK_SEL_O}, 16'h0003);
        $display("clock select test done");
    endtask

    task automatic complete_run;
        $display("Checks %0d, mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge SYS_CLK_I);
        RST_B_I <= 1'b1;
        @(posedge SYS_CLK_I);
        t_lock();
        t_time();
        t_alarm();
        t_clk();
        complete_run();
    end

    // Tests need about 140 cycles; the limit leaves wide margin
    initial begin
        #50000;
        err_count++;
        complete_run();
    end
endmodule

bind rcw_top rcw_checker rcw_checker_inst (.*);
